/* include/mrsx_cfg.svh */
// Constants of the rotate, subtract and skip execution unit.
// How it works
// - Return with immediate: reload PC, load accumulator.
// - Interrupt return reloads PC, sets interrupt gate.
// - Pending request is serviced before main program.
// - Rotate left moves bit 7 to 0.
// - Accumulator rotates leave memory byte untouched.
// - Rotate left through carry, nine bit ring.
// - Rotate right moves bit 0 to 7.
// - Rotate right through carry, nine bit ring.
// - Subtract with borrow uses inverted carry.
// - Carry clear on negative, set otherwise.
// - Plain subtract from memory or immediate byte.
// - Decrement memory, skip when result is zero.
// - Increment memory, skip when result wraps.
// - Accumulator forms put result in accumulator, keep memory.
// - Taken skip adds one dummy slot, no flags.
// - Bit test skips when selected bit set.
// - Byte set writes all ones.
// - Bit set forces one selected bit.
// - Nibble swap writes back to memory byte.
`ifndef MRSX_CFG_SVH
`define MRSX_CFG_SVH
`define MRSX_PC_W       13
`define MRSX_ACC_RST    8'h00
`define MRSX_FLAG_RST   1'b0
`define MRSX_GATE_RST   1'b0
`define MRSX_ALL_ONES   8'hFF
`define MRSX_ONE        8'h01
`endif

/* include/mrsx_pkg.sv */
// Types shared by the execution unit and its bench.
`default_nettype none
package mrsx_pkg;
   // Operations this unit executes; others are handled elsewhere in the core.
   typedef enum logic [4:0] {
      op_nop                         = 5'h00,
      op_return_imm                  = 5'h01,
      interrupt_return_op            = 5'h02,
      rotate_left_op                 = 5'h03,
      rotate_left_to_acc             = 5'h04,
      rotate_left_thru_carry         = 5'h05,
      rotate_left_thru_carry_to_acc  = 5'h06,
      rotate_right_op                = 5'h07,
      rotate_right_to_acc            = 5'h08,
      rotate_right_thru_carry        = 5'h09,
      rotate_right_thru_carry_to_acc = 5'h0A,
      minus_with_borrow_op           = 5'h0B,
      minus_with_borrow_to_mem       = 5'h0C,
      minus_op                       = 5'h0D,
      minus_to_mem                   = 5'h0E,
      minus_imm_op                   = 5'h0F,
      decrement_skip_if_null         = 5'h10,
      decrement_skip_to_acc          = 5'h11,
      increment_skip_if_null         = 5'h12,
      increment_skip_to_acc          = 5'h13,
      bit_set_skip                   = 5'h14,
      byte_set_op                    = 5'h15,
      bit_set_op                     = 5'h16,
      nibble_swap_op                 = 5'h17
   } mrsx_op_t;

   // Execution slot: a normal slot or the dummy slot after a taken skip.
   typedef enum logic {
      st_exec  = 1'b0,
      st_dummy = 1'b1
   } mrsx_state_t;
endpackage : mrsx_pkg
`default_nettype wire

/* rtl/mrsx_exec.sv */
// Execution unit for rotate, subtract, skip, set, swap and return operations.
`include "mrsx_cfg.svh"
`default_nettype none
module mrsx_exec
   import mrsx_pkg::*;
(
   input  wire logic                   sys_clk,            // System clock, 100 MHz.
   input  wire logic                   reset_n,            // Synchronous reset, active low.
   input  wire logic                   op_valid,           // Operation offered this cycle.
   input  wire mrsx_op_t               op_code,            // Operation to execute.
   input  wire logic [7:0]             mem_rdata,          // Addressed memory byte.
   input  wire logic [7:0]             imm_data,           // Immediate byte of the instruction.
   input  wire logic [2:0]             bit_sel,            // Bit number for bit forms.
   input  wire logic [`MRSX_PC_W-1:0]  stack_pc,           // Top of the return stack.
   input  wire logic                   irq_pending,        // Interrupt request waiting.
   input  wire logic                   irq_entry,          // Core enters an interrupt routine.
   output logic                        op_ready,           // Unit takes an operation.
   output logic [7:0]                  acc,                // Accumulator.
   output logic                        carry_flag,         // Carry flag.
   output logic                        half_carry_flag,    // Half carry flag.
   output logic                        null_flag,          // Zero result flag.
   output logic                        signed_excess_flag, // Overflow flag.
   output logic                        mem_we,             // Memory write pulse.
   output logic [7:0]                  mem_wdata,          // Memory write data.
   output logic                        pc_load,            // Program counter reload pulse.
   output logic [`MRSX_PC_W-1:0]       pc_value,           // Program counter reload value.
   output logic                        master_irq_gate,    // Master interrupt enable.
   output logic                        irq_service,        // Service pending request first.
   output logic                        dummy_slot          // Dummy slot of a taken skip.
);

   logic [7:0]             acc_r;
   logic [7:0]             acc_nxt;
   logic                   acc_we;
   logic                   carry_r;
   logic                   carry_nxt;
   logic                   hc_r;
   logic                   z_r;
   logic                   sx_r;
   logic                   arith_we;
   logic                   carry_we;
   logic                   mem_we_r;
   logic                   mem_we_nxt;
   logic [7:0]             mem_wdata_r;
   logic [7:0]             res;
   logic                   skip_nxt;
   logic                   pc_load_r;
   logic [`MRSX_PC_W-1:0]  pc_value_r;
   logic                   gate_r;
   logic                   irq_service_r;
   logic                   dummy_r;
   logic                   ready_r;
   logic                   accept;
   logic                   is_return;
   logic                   is_iret;
   logic [11:0]            sub_out;
   logic [7:0]             bit_mask;
   mrsx_state_t            state_r;
   mrsx_state_t            state_nxt;

   // Subtract by adding the complement: carry set means no borrow.
   // Result packs {excess, null, half carry, carry, difference}.
   function automatic logic [11:0] sub_calc(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      logic       ovf;
      full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      ovf  = (a[7] != b[7]) && (full[7] != a[7]);
      sub_calc = {ovf, (full[7:0] == 8'h00), low[4], full[8], full[7:0]};
   endfunction : sub_calc

   // Rotate helpers shared by the memory and accumulator forms.
   function automatic logic [7:0] rot_l(input logic [7:0] v, input logic fill);
      rot_l = {v[6:0], fill};
   endfunction : rot_l

   function automatic logic [7:0] rot_r(input logic [7:0] v, input logic fill);
      rot_r = {fill, v[7:1]};
   endfunction : rot_r

   assign accept    = op_valid && ready_r;
   assign bit_mask  = `MRSX_ONE << bit_sel;
   assign is_return = accept && (op_code == op_return_imm);
   assign is_iret   = accept && (op_code == interrupt_return_op);

   // Subtractor operands: immediate form takes the instruction byte, borrow forms take the carry.
   always_comb begin
      logic [7:0] b_opnd;
      logic       c_in;
      b_opnd = (op_code == minus_imm_op) ? imm_data : mem_rdata;
      c_in   = ((op_code == minus_with_borrow_op) || (op_code == minus_with_borrow_to_mem)) ? carry_r : 1'b1;
      sub_out = sub_calc(acc_r, b_opnd, c_in);
   end

   // Operation decode: result, destination, flag updates and skip decision.
   always_comb begin
      res        = mem_rdata;
      acc_nxt    = acc_r;
      acc_we     = 1'b0;
      mem_we_nxt = 1'b0;
      carry_nxt  = carry_r;
      carry_we   = 1'b0;
      arith_we   = 1'b0;
      skip_nxt   = 1'b0;
      if (accept) begin
         unique case (op_code)
            op_return_imm: begin
               acc_nxt = imm_data;
               acc_we  = 1'b1;
            end
            rotate_left_op: begin
               res        = rot_l(mem_rdata, mem_rdata[7]);
               mem_we_nxt = 1'b1;
            end
            rotate_left_to_acc: begin
               acc_nxt = rot_l(mem_rdata, mem_rdata[7]);
               acc_we  = 1'b1;
            end
            rotate_left_thru_carry, rotate_left_thru_carry_to_acc: begin
               res       = rot_l(mem_rdata, carry_r);
               carry_nxt = mem_rdata[7];
               carry_we  = 1'b1;
               acc_nxt   = res;
               acc_we    = (op_code == rotate_left_thru_carry_to_acc);
               mem_we_nxt = (op_code == rotate_left_thru_carry);
            end
            rotate_right_op: begin
               res        = rot_r(mem_rdata, mem_rdata[0]);
               mem_we_nxt = 1'b1;
            end
            rotate_right_to_acc: begin
               acc_nxt = rot_r(mem_rdata, mem_rdata[0]);
               acc_we  = 1'b1;
            end
            rotate_right_thru_carry, rotate_right_thru_carry_to_acc: begin
               res       = rot_r(mem_rdata, carry_r);
               carry_nxt = mem_rdata[0];
               carry_we  = 1'b1;
               acc_nxt   = res;
               acc_we    = (op_code == rotate_right_thru_carry_to_acc);
               mem_we_nxt = (op_code == rotate_right_thru_carry);
            end
            minus_with_borrow_op, minus_op, minus_imm_op: begin
               acc_nxt  = sub_out[7:0];
               acc_we   = 1'b1;
               arith_we = 1'b1;
            end
            minus_with_borrow_to_mem, minus_to_mem: begin
               res        = sub_out[7:0];
               mem_we_nxt = 1'b1;
               arith_we   = 1'b1;
            end
            decrement_skip_if_null, decrement_skip_to_acc: begin
               res        = mem_rdata - `MRSX_ONE;
               skip_nxt   = (res == 8'h00);
               acc_nxt    = res;
               acc_we     = (op_code == decrement_skip_to_acc);
               mem_we_nxt = (op_code == decrement_skip_if_null);
            end
            increment_skip_if_null, increment_skip_to_acc: begin
               res        = mem_rdata + `MRSX_ONE;
               skip_nxt   = (res == 8'h00);
               acc_nxt    = res;
               acc_we     = (op_code == increment_skip_to_acc);
               mem_we_nxt = (op_code == increment_skip_if_null);
            end
            bit_set_skip: begin
               skip_nxt = ((mem_rdata & bit_mask) != 8'h00);
            end
            byte_set_op: begin
               res        = `MRSX_ALL_ONES;
               mem_we_nxt = 1'b1;
            end
            bit_set_op: begin
               res        = mem_rdata | bit_mask;
               mem_we_nxt = 1'b1;
            end
            nibble_swap_op: begin
               res        = {mem_rdata[3:0], mem_rdata[7:4]};
               mem_we_nxt = 1'b1;
            end
            default: begin
               res = mem_rdata;
            end
         endcase
      end
   end

   // Accumulator; only the forms that name it as destination write it.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         acc_r <= `MRSX_ACC_RST;
      end else if (acc_we) begin
         acc_r <= acc_nxt;
      end
   end

   // Carry is written by subtracts and carry rotates; skip and set forms leave it.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         carry_r <= `MRSX_FLAG_RST;
      end else if (arith_we) begin
         carry_r <= sub_out[8];
      end else if (carry_we) begin
         carry_r <= carry_nxt;
      end
   end

   // The remaining arithmetic flags move only on subtracts.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hc_r <= `MRSX_FLAG_RST;
         z_r  <= `MRSX_FLAG_RST;
         sx_r <= `MRSX_FLAG_RST;
      end else if (arith_we) begin
         hc_r <= sub_out[9];
         z_r  <= sub_out[10];
         sx_r <= sub_out[11];
      end
   end

   // Memory write port; data is held registered so the store lands one cycle later.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mem_we_r    <= 1'b0;
         mem_wdata_r <= 8'h00;
      end else begin
         mem_we_r    <= mem_we_nxt;
         mem_wdata_r <= res;
      end
   end

   // Program counter reload from the stack for both return forms.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pc_load_r  <= 1'b0;
         pc_value_r <= '0;
      end else begin
         pc_load_r  <= is_return || is_iret;
         pc_value_r <= stack_pc;
      end
   end

   // Master interrupt gate: the interrupt return sets it and wins over a same-cycle entry clear.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         gate_r <= `MRSX_GATE_RST;
      end else if (is_iret) begin
         gate_r <= 1'b1;
      end else if (irq_entry) begin
         gate_r <= 1'b0;
      end
   end

   // A request already waiting is flagged so the core vectors before resuming the main program.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irq_service_r <= 1'b0;
      end else begin
         irq_service_r <= is_iret && irq_pending;
      end
   end

   // Slot sequencing: a taken skip costs exactly one dummy slot.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         st_exec: begin
            if (skip_nxt) begin
               state_nxt = st_dummy;
            end
         end
         st_dummy: begin
            state_nxt = st_exec;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_r <= st_exec;
         dummy_r <= 1'b0;
         ready_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         dummy_r <= (state_nxt == st_dummy);
         ready_r <= (state_nxt == st_exec);
      end
   end

   assign op_ready           = ready_r;
   assign acc                = acc_r;
   assign carry_flag         = carry_r;
   assign half_carry_flag    = hc_r;
   assign null_flag          = z_r;
   assign signed_excess_flag = sx_r;
   assign mem_we             = mem_we_r;
   assign mem_wdata          = mem_wdata_r;
   assign pc_load            = pc_load_r;
   assign pc_value           = pc_value_r;
   assign master_irq_gate    = gate_r;
   assign irq_service        = irq_service_r;
   assign dummy_slot         = dummy_r;

   // Checks of the documented behaviour, clocked on the system clock.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_take(mrsx_op_t o);
      op_valid && op_ready && (op_code == o);
   endsequence

   sequence s_dummy_then_ready;
      dummy_slot && !op_ready ##1 !dummy_slot && op_ready;
   endsequence

   a_ret_imm_load: assert property (s_take(op_return_imm) |=>
      pc_load && (pc_value == $past(stack_pc)) && (acc == $past(imm_data)) && $stable(carry_flag))
      else $error("Return with immediate did not reload PC and accumulator.");

   a_iret_gate_set: assert property (s_take(interrupt_return_op) |=>
      master_irq_gate && pc_load && $stable(null_flag) && $stable(carry_flag))
      else $error("Interrupt return did not set the gate.");

   a_iret_pending: assert property (s_take(interrupt_return_op) ##0 irq_pending |=> irq_service)
      else $error("Pending request not flagged on interrupt return.");

   a_rot_left_mem: assert property (s_take(rotate_left_op) |=>
      mem_we && (mem_wdata == rot_l($past(mem_rdata), $past(mem_rdata[7]))) && $stable(carry_flag))
      else $error("Rotate left wrote a wrong byte.");

   a_rot_acc_only: assert property ((s_take(rotate_left_to_acc) or s_take(rotate_right_thru_carry_to_acc))
      |=> !mem_we)
      else $error("Accumulator rotate wrote memory.");

   a_rotl_carry: assert property (s_take(rotate_left_thru_carry) |=>
      (carry_flag == $past(mem_rdata[7])) && (mem_wdata[0] == $past(carry_flag)))
      else $error("Rotate left through carry broke the ring.");

   a_rot_right_acc: assert property (s_take(rotate_right_to_acc) |=>
      acc == rot_r($past(mem_rdata), $past(mem_rdata[0])))
      else $error("Rotate right gave a wrong accumulator.");

   a_rotr_carry: assert property (s_take(rotate_right_thru_carry) |=>
      (carry_flag == $past(mem_rdata[0])) && (mem_wdata[7] == $past(carry_flag)))
      else $error("Rotate right through carry broke the ring.");

   a_borrow_value: assert property (s_take(minus_with_borrow_op) |=>
      (acc == $past(acc - mem_rdata - {7'h00, !carry_flag})) &&
      (carry_flag == ($past(acc) >= $past(mem_rdata) + {8'h00, !$past(carry_flag)})))
      else $error("Subtract with borrow result or carry wrong.");

   a_sub_mem_dest: assert property (s_take(minus_to_mem) |=>
      mem_we && (mem_wdata == $past(acc - mem_rdata)) && (null_flag == (mem_wdata == 8'h00)))
      else $error("Subtract to memory wrong.");

   a_dec_skip: assert property (s_take(decrement_skip_if_null) ##0 (mem_rdata == 8'h01)
      |=> mem_we && (mem_wdata == 8'h00) ##0 s_dummy_then_ready)
      else $error("Decrement to zero did not skip.");

   a_inc_noskip: assert property (s_take(increment_skip_if_null) ##0 (mem_rdata != 8'hFF)
      |=> !dummy_slot && op_ready && (mem_wdata == $past(mem_rdata) + 8'h01))
      else $error("Increment skipped on nonzero result.");

   a_acc_skip_form: assert property (s_take(increment_skip_to_acc) |=>
      !mem_we && (acc == $past(mem_rdata) + 8'h01) && (dummy_slot == (acc == 8'h00)))
      else $error("Accumulator increment-skip wrong.");

   a_skip_flags: assert property (s_take(decrement_skip_to_acc) |=>
      $stable(carry_flag) && $stable(null_flag) && $stable(signed_excess_flag))
      else $error("Skip form changed a flag.");

   a_bit_skip: assert property (s_take(bit_set_skip) |=> dummy_slot == $past(mem_rdata[bit_sel]))
      else $error("Bit test skip decision wrong.");

   a_byte_set: assert property (s_take(byte_set_op) |=> mem_we && (mem_wdata == 8'hFF))
      else $error("Byte set did not write all ones.");

   a_bit_set: assert property (s_take(bit_set_op) |=>
      mem_we && (mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel)))))
      else $error("Bit set wrote a wrong byte.");

   a_nibble_swap: assert property (s_take(nibble_swap_op) |=>
      mem_we && (mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}))
      else $error("Nibble swap wrote a wrong byte.");

endmodule : mrsx_exec
`default_nettype wire

/* verification/mrsx_exec_test.sv */
// Self-checking bench for the rotate, subtract and skip execution unit.
`include "mrsx_cfg.svh"
`default_nettype none
module mcu_rotate_subtract_skip_exec_test import mrsx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, irq_pending = 1'b0, irq_entry = 1'b0;
   mrsx_op_t op_code = op_nop;
   logic [7:0] mem_rdata = 8'h00, imm_data = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [`MRSX_PC_W-1:0] stack_pc = '0, pc_value;
   logic op_ready, carry_flag, half_carry_flag, null_flag, signed_excess_flag;
   logic mem_we, pc_load, master_irq_gate, irq_service, dummy_slot;
   logic [7:0] acc, mem_wdata;
   int err_count = 0, comparisons = 0;
   logic [2:0] hzv_e = 3'h0;

   // One row: op, acc preset, operand, carry preset, then expected acc, carry, write, data, skip, flags.
   typedef struct packed {
      mrsx_op_t op; logic [7:0] a, m; logic ci; logic [7:0] ea; logic ec, we; logic [7:0] wd;
      logic sk; logic [3:0] f;
   } mrsx_row_t;
   mrsx_row_t rows [22] = '{
      '{rotate_left_op, 8'h55, 8'h81, 1'b1, 8'h55, 1'b1, 1'b1, 8'h03, 1'b0, 4'h0},
      '{rotate_left_to_acc, 8'h00, 8'h81, 1'b0, 8'h03, 1'b0, 1'b0, 8'h00, 1'b0, 4'h0},
      '{rotate_left_thru_carry, 8'h11, 8'h81, 1'b0, 8'h11, 1'b1, 1'b1, 8'h02, 1'b0, 4'h0},
      '{rotate_left_thru_carry_to_acc, 8'h00, 8'h40, 1'b1, 8'h81, 1'b0, 1'b0, 8'h00, 1'b0, 4'h0},
      '{rotate_right_op, 8'h22, 8'h81, 1'b0, 8'h22, 1'b0, 1'b1, 8'hC0, 1'b0, 4'h0},
      '{rotate_right_to_acc, 8'h00, 8'h02, 1'b1, 8'h01, 1'b1, 1'b0, 8'h00, 1'b0, 4'h0},
      '{rotate_right_thru_carry, 8'h33, 8'h01, 1'b0, 8'h33, 1'b1, 1'b1, 8'h00, 1'b0, 4'h0},
      '{rotate_right_thru_carry_to_acc, 8'h00, 8'h02, 1'b1, 8'h81, 1'b0, 1'b0, 8'h00, 1'b0, 4'h0},
      '{minus_op, 8'h50, 8'h30, 1'b0, 8'h20, 1'b1, 1'b0, 8'h00, 1'b0, 4'hC},
      '{minus_op, 8'h80, 8'h01, 1'b0, 8'h7F, 1'b1, 1'b0, 8'h00, 1'b0, 4'h9},
      '{minus_with_borrow_op, 8'h10, 8'h10, 1'b0, 8'hFF, 1'b0, 1'b0, 8'h00, 1'b0, 4'h8},
      '{minus_with_borrow_to_mem, 8'h10, 8'h0F, 1'b1, 8'h10, 1'b1, 1'b1, 8'h01, 1'b0, 4'h8},
      '{minus_to_mem, 8'h05, 8'h05, 1'b0, 8'h05, 1'b1, 1'b1, 8'h00, 1'b0, 4'hE},
      '{minus_imm_op, 8'h03, 8'h04, 1'b0, 8'hFF, 1'b0, 1'b0, 8'h00, 1'b0, 4'h8},
      '{decrement_skip_if_null, 8'h44, 8'h01, 1'b0, 8'h44, 1'b0, 1'b1, 8'h00, 1'b1, 4'h0},
      '{decrement_skip_if_null, 8'h44, 8'h00, 1'b1, 8'h44, 1'b1, 1'b1, 8'hFF, 1'b0, 4'h0},
      '{decrement_skip_to_acc, 8'h44, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 4'h0},
      '{increment_skip_if_null, 8'h44, 8'hFF, 1'b1, 8'h44, 1'b1, 1'b1, 8'h00, 1'b1, 4'h0},
      '{increment_skip_if_null, 8'h44, 8'h7F, 1'b0, 8'h44, 1'b0, 1'b1, 8'h80, 1'b0, 4'h0},
      '{increment_skip_to_acc, 8'h44, 8'h05, 1'b0, 8'h06, 1'b0, 1'b0, 8'h00, 1'b0, 4'h0},
      '{byte_set_op, 8'h44, 8'h12, 1'b0, 8'h44, 1'b0, 1'b1, 8'hFF, 1'b0, 4'h0},
      '{nibble_swap_op, 8'h44, 8'hA5, 1'b1, 8'h44, 1'b1, 1'b1, 8'h5A, 1'b0, 4'h0}};

   mrsx_exec u_mrsx_exec (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .stack_pc(stack_pc),
      .irq_pending(irq_pending), .irq_entry(irq_entry), .op_ready(op_ready), .acc(acc),
      .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .null_flag(null_flag),
      .signed_excess_flag(signed_excess_flag), .mem_we(mem_we), .mem_wdata(mem_wdata), .pc_load(pc_load),
      .pc_value(pc_value), .master_irq_gate(master_irq_gate), .irq_service(irq_service),
      .dummy_slot(dummy_slot));

   // The clock toggles every half period of 5 ns, a 10 ns period.
   always #5 sys_clk = ~sys_clk;

   // Compares one observed value and reports a mismatch at once.
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Offers an operation; the immediate path gets a different memory byte so a wrong source shows.
   task automatic drive(input mrsx_op_t o, input logic [7:0] m, input logic [2:0] b);
      op_valid = 1'b1;
      op_code = o;
      imm_data = m;
      mem_rdata = (o == minus_imm_op) ? ~m : m;
      bit_sel = b;
   endtask : drive

   // Runs one operation and returns at the falling edge where its effects are visible.
   task automatic run(input mrsx_op_t o, input logic [7:0] m, input logic [2:0] b);
      @(negedge sys_clk);
      drive(o, m, b);
      @(negedge sys_clk);
      op_valid = 1'b0;
   endtask : run

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // The run needs a few hundred cycles; a hang is cut short at five thousand.
   initial begin
      #50000;
      err_count++;
      end_of_test();
   end

   initial begin
      repeat (10) @(negedge sys_clk);
      reset_n = 1'b1;
      chk("reset acc", 8'h00, acc);
      chk("reset state", 16'h0010, {carry_flag, half_carry_flag, null_flag, signed_excess_flag,
         master_irq_gate, op_ready, mem_we, pc_load, irq_service, dummy_slot});
      // Presets go through the carry rotate on memory and the immediate return, neither touching other flags.
      foreach (rows[i]) begin
         run(rotate_left_thru_carry, rows[i].ci ? 8'h80 : 8'h00, 3'h0);
         run(op_return_imm, rows[i].a, 3'h0);
         run(rows[i].op, rows[i].m, 3'h0);
         if (rows[i].f[3]) hzv_e = rows[i].f[2:0];
         chk("acc", rows[i].ea, acc);
         chk("carry", rows[i].ec, carry_flag);
         chk("flags", hzv_e, {half_carry_flag, null_flag, signed_excess_flag});
         chk("write", rows[i].we, mem_we);
         if (rows[i].we) chk("wdata", rows[i].wd, mem_wdata);
         chk("skip", {rows[i].sk, ~rows[i].sk}, {dummy_slot, op_ready});
         if (rows[i].sk) @(negedge sys_clk);
      end
      // Every bit position for the bit set and the bit test, both senses.
      for (int b = 0; b < 8; b++) begin
         run(bit_set_op, 8'h00, 3'(b));
         chk("bit set", 8'h01 << b, mem_wdata);
         run(bit_set_skip, 8'h01 << b, 3'(b));
         chk("bit skip", 1'b1, dummy_slot);
         @(negedge sys_clk);
         run(bit_set_skip, 8'h01 << b, 3'(b + 1));
         chk("bit pass", 1'b0, dummy_slot);
      end
      // Immediate return reloads the counter and the accumulator only.
      stack_pc = 13'h1A5C;
      run(op_return_imm, 8'h3C, 3'h0);
      chk("ret pc", {1'b1, 13'h1A5C}, {pc_load, pc_value});
      chk("ret acc", 8'h3C, acc);
      // Interrupt return with a request waiting, then the core's entry closes the gate.
      irq_pending = 1'b1;
      run(interrupt_return_op, 8'h00, 3'h0);
      chk("iret", 4'hF, {pc_load, master_irq_gate, irq_service, stack_pc == pc_value});
      chk("iret acc", 8'h3C, acc);
      irq_pending = 1'b0;
      irq_entry = 1'b1;
      @(negedge sys_clk);
      irq_entry = 1'b0;
      chk("gate off", 1'b0, master_irq_gate);
      run(interrupt_return_op, 8'h00, 3'h0);
      chk("iret quiet", 2'b10, {master_irq_gate, irq_service});
      // An offer during the dummy slot is refused and leaves no trace.
      @(negedge sys_clk);
      drive(decrement_skip_to_acc, 8'h01, 3'h0);
      @(negedge sys_clk);
      chk("dummy", 2'b10, {dummy_slot, op_ready});
      drive(op_return_imm, 8'h77, 3'h0);
      @(negedge sys_clk);
      op_valid = 1'b0;
      chk("refused", 10'h000, {acc, pc_load, dummy_slot});
      end_of_test();
   end
endmodule : mcu_rotate_subtract_skip_exec_test
`default_nettype wire
